// ==== core/sicc_consts.vh ====
// Constants for the stage input connection configuration bank
`ifndef SICC_CONSTS_VH
`define SICC_CONSTS_VH

`define SICC_ADDR_W          10
`define SICC_DATA_W          16
`define SICC_STAGE_W         4
`define SICC_STAGE_COUNT     4'hc
`define SICC_INPUT_COUNT     13
`define SICC_LOW_INPUTS      7

`define SICC_STAGE_BASE      10'h080
`define SICC_STAGE_STRIDE    10'h008
`define SICC_STAGE_SPAN      10'h060
`define SICC_OFS_LOW         3'h0
`define SICC_OFS_HIGH        3'h1
`define SICC_STATUS_ADDR     10'h0e0

`define SICC_LOW_USED_MASK   16'h3fff
`define SICC_HIGH_FIELD_BASE 16

`define SICC_CODE_OPEN       2'h0
`define SICC_CODE_NEG        2'h1
`define SICC_CODE_POS        2'h2
`define SICC_CODE_BIAS       2'h3

`define SICC_TYPE_LSB        28
`define SICC_TYPE_MSB        29
`define SICC_NEG_OFF_BIT     30
`define SICC_POS_OFF_BIT     31

`define SICC_TYPE_BAD        2'h0
`define SICC_TYPE_SE_POS     2'h1
`define SICC_TYPE_SE_NEG     2'h2
`define SICC_TYPE_DIFF       2'h3

`define SICC_ST_STAGE_LSB    0
`define SICC_ST_STAGE_MSB    3
`define SICC_ST_VALID_BIT    4
`define SICC_ST_TYPE_LSB     5
`define SICC_ST_TYPE_MSB     6
`define SICC_ST_BAD_BIT      8

`define SICC_RST_DATA        16'h0000
`define SICC_RST_WORD        32'h0000_0000
`define SICC_RST_SEL         13'h0000
`define SICC_RST_STAGE       4'h0
`define SICC_RST_TYPE        2'h0

`endif

// ==== core/sicc_stage_mem.v ====
// Per-stage connection word store with registered read ports
`timescale 1ns/10ps
`include "sicc_consts.vh"

module sicc_stage_mem (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // Write port
    input  wire        i_wr_en,
    input  wire [3:0]  i_wr_idx,
    input  wire        i_wr_half,
    input  wire [15:0] i_wr_data,
    // Bus read port
    input  wire        i_a_rd,
    input  wire [3:0]  i_a_idx,
    input  wire        i_a_half,
    output reg  [15:0] o_a_data,
    // Stage read port
    input  wire        i_b_en,
    input  wire [3:0]  i_b_idx,
    output reg  [31:0] o_b_data
);

    // Contents carry no reset: software must program each stage
    reg [31:0] mem [0:11];

    always @(posedge i_clk) begin
        if (i_wr_en) begin
            if (i_wr_half) begin
                mem[i_wr_idx][31:16] <= i_wr_data;
            end else begin
                mem[i_wr_idx][15:0] <= i_wr_data;
            end
        end
    end

    // Zero when idle so the top can merge read sources by OR
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_a_data <= `SICC_RST_DATA;
            o_b_data <= `SICC_RST_WORD;
        end else begin
            if (i_a_rd) begin
                o_a_data <= i_a_half ? mem[i_a_idx][31:16] : mem[i_a_idx][15:0];
            end else begin
                o_a_data <= `SICC_RST_DATA;
            end
            if (i_b_en) begin
                o_b_data <= mem[i_b_idx];
            end else begin
                o_b_data <= `SICC_RST_WORD;
            end
        end
    end

endmodule // sicc_stage_mem

// ==== core/sicc_stage_config.v ====
// Stage input connection configuration bank and switch matrix control
`timescale 1ns/10ps
`include "sicc_consts.vh"

module sicc_stage_config (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // Register port
    input  wire [9:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output wire [15:0] o_rdata,
    // Sequencer stage select
    input  wire [3:0]  i_stage,
    // Switch matrix control
    output reg  [12:0] o_pos_sel,
    output reg  [12:0] o_neg_sel,
    output reg  [12:0] o_bias_sel,
    // Measurement type and offset control
    output reg         o_se_pos,
    output reg         o_se_neg,
    output reg         o_diff,
    output reg         o_type_bad,
    output reg         o_neg_offset_en,
    output reg         o_pos_offset_en,
    output reg         o_stage_active
);

    // Decode: {hit, half, stage index}
    function [5:0] sicc_decode;
        input [9:0] addr;
        reg   [9:0] off;
        begin
            off = addr - `SICC_STAGE_BASE;
            sicc_decode = 6'h00;
            if ((addr >= `SICC_STAGE_BASE) && (off < `SICC_STAGE_SPAN) && (off[2:1] == 2'h0)) begin
                sicc_decode = {1'b1, off[0], off[6:3]};
            end
        end
    endfunction

    wire [5:0]  wr_dec;
    wire [5:0]  rd_dec;
    wire        wr_hit;
    wire        rd_hit;
    wire        status_wr;
    wire        status_rd;
    wire [15:0] wr_word;
    wire [15:0] mem_rdata;
    wire [31:0] stage_word;
    wire        stage_ok;

    reg         stage_ok_reg;
    reg  [3:0]  stage_idx_reg;
    reg  [3:0]  applied_stage_reg;
    reg         applied_valid_reg;
    reg  [1:0]  applied_type_reg;
    reg         bad_seen_reg;
    reg         bad_seen_next;
    reg  [15:0] status_rdata_reg;

    reg  [12:0] pos_next;
    reg  [12:0] neg_next;
    reg  [12:0] bias_next;
    wire [1:0]  type_code;

    assign wr_dec    = sicc_decode(i_addr);
    assign rd_dec    = sicc_decode(i_addr);
    assign wr_hit    = i_wr & wr_dec[5];
    assign rd_hit    = i_rd & rd_dec[5];
    assign status_wr = i_wr & (i_addr == `SICC_STATUS_ADDR);
    assign status_rd = i_rd & (i_addr == `SICC_STATUS_ADDR);
    assign stage_ok  = (i_stage < `SICC_STAGE_COUNT);

    // Unused top bits of the first register are never stored
    assign wr_word = wr_dec[4] ? i_wdata : (i_wdata & `SICC_LOW_USED_MASK);

    sicc_stage_mem u_mem (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_wr_en   (wr_hit),
        .i_wr_idx  (wr_dec[3:0]),
        .i_wr_half (wr_dec[4]),
        .i_wr_data (wr_word),
        .i_a_rd    (rd_hit),
        .i_a_idx   (rd_dec[3:0]),
        .i_a_half  (rd_dec[4]),
        .o_a_data  (mem_rdata),
        .i_b_en    (stage_ok),
        .i_b_idx   (i_stage),
        .o_b_data  (stage_word)
    );

    // Both sources are zero unless selected, unmapped reads give zero
    assign o_rdata = mem_rdata | status_rdata_reg;

    // Per-input routing decode across both registers
    genvar gi;
    generate
        for (gi = 0; gi < `SICC_INPUT_COUNT; gi = gi + 1) begin : g_route
            localparam integer LSB = (gi < `SICC_LOW_INPUTS) ? (2 * gi) :
                                     (`SICC_HIGH_FIELD_BASE + 2 * (gi - `SICC_LOW_INPUTS));
            wire [1:0] code;
            assign code = stage_word[LSB + 1:LSB];
            always @* begin
                pos_next[gi]  = stage_ok_reg & (code == `SICC_CODE_POS);
                neg_next[gi]  = stage_ok_reg & (code == `SICC_CODE_NEG);
                bias_next[gi] = stage_ok_reg & (code == `SICC_CODE_BIAS);
                // Code 00 leaves all three switches open
                if (code == `SICC_CODE_OPEN) begin
                    pos_next[gi]  = 1'b0;
                    neg_next[gi]  = 1'b0;
                    bias_next[gi] = 1'b0;
                end
            end
        end
    endgenerate

    assign type_code = stage_word[`SICC_TYPE_MSB:`SICC_TYPE_LSB];

    // Sticky prohibited-type flag, set wins over software clear
    always @* begin
        bad_seen_next = bad_seen_reg;
        if (status_wr && i_wdata[`SICC_ST_BAD_BIT]) begin
            bad_seen_next = 1'b0;
        end
        if (stage_ok_reg && (type_code == `SICC_TYPE_BAD)) begin
            bad_seen_next = 1'b1;
        end
    end

    // Stage select is registered with the memory read to stay aligned
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage_ok_reg  <= 1'b0;
            stage_idx_reg <= `SICC_RST_STAGE;
        end else begin
            stage_ok_reg  <= stage_ok;
            stage_idx_reg <= i_stage;
        end
    end

    // Switch and mode outputs, two cycles after the stage select
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pos_sel       <= `SICC_RST_SEL;
            o_neg_sel       <= `SICC_RST_SEL;
            o_bias_sel      <= `SICC_RST_SEL;
            o_se_pos        <= 1'b0;
            o_se_neg        <= 1'b0;
            o_diff          <= 1'b0;
            o_type_bad      <= 1'b0;
            o_neg_offset_en <= 1'b0;
            o_pos_offset_en <= 1'b0;
            o_stage_active  <= 1'b0;
        end else begin
            o_pos_sel       <= pos_next;
            o_neg_sel       <= neg_next;
            o_bias_sel      <= bias_next;
            o_se_pos        <= stage_ok_reg & (type_code == `SICC_TYPE_SE_POS);
            o_se_neg        <= stage_ok_reg & (type_code == `SICC_TYPE_SE_NEG);
            o_diff          <= stage_ok_reg & (type_code == `SICC_TYPE_DIFF);
            o_type_bad      <= stage_ok_reg & (type_code == `SICC_TYPE_BAD);
            o_neg_offset_en <= stage_ok_reg & ~stage_word[`SICC_NEG_OFF_BIT];
            o_pos_offset_en <= stage_ok_reg & ~stage_word[`SICC_POS_OFF_BIT];
            o_stage_active  <= stage_ok_reg;
        end
    end

    // Status register: applied stage, its type and the sticky flag
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            applied_stage_reg <= `SICC_RST_STAGE;
            applied_valid_reg <= 1'b0;
            applied_type_reg  <= `SICC_RST_TYPE;
            bad_seen_reg      <= 1'b0;
            status_rdata_reg  <= `SICC_RST_DATA;
        end else begin
            applied_stage_reg <= stage_idx_reg;
            applied_valid_reg <= stage_ok_reg;
            applied_type_reg  <= stage_ok_reg ? type_code : `SICC_RST_TYPE;
            bad_seen_reg      <= bad_seen_next;
            if (status_rd) begin
                status_rdata_reg <= {7'h00, bad_seen_reg, 1'b0, applied_type_reg,
                                     applied_valid_reg, applied_stage_reg};
            end else begin
                status_rdata_reg <= `SICC_RST_DATA;
            end
        end
    end

endmodule // sicc_stage_config

// ==== tb/sicc_stage_config_properties.sv ====
// Assertions for the stage connection configuration bank
`timescale 1ns/10ps
module sicc_props (
    input wire        i_clk,
    input wire        i_rst_b,
    input wire [9:0]  i_addr,
    input wire [15:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [15:0] o_rdata,
    input wire [3:0]  i_stage,
    input wire [12:0] o_pos_sel,
    input wire [12:0] o_neg_sel,
    input wire [12:0] o_bias_sel,
    input wire        o_se_pos,
    input wire        o_se_neg,
    input wire        o_diff,
    input wire        o_type_bad,
    input wire        o_neg_offset_en,
    input wire        o_pos_offset_en,
    input wire        o_stage_active
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Address falls inside one of the twelve stage blocks
    wire blk = i_addr[9:3] >= 7'h10 && i_addr[9:3] <= 7'h1b;

    chk_sel_disjoint: assert property (((o_pos_sel & o_neg_sel) | (o_bias_sel & (o_pos_sel | o_neg_sel))) == 0)
        else $error("switch selections overlap");
    chk_one_type: assert property (o_stage_active |-> $onehot({o_se_pos, o_se_neg, o_diff, o_type_bad}))
        else $error("measurement type not one-hot");
    chk_idle_stage: assert property (i_stage >= 4'hc |-> ##2 !o_stage_active)
        else $error("idle stage shows as active");
    chk_valid_stage: assert property (i_stage < 4'hc |-> ##2 o_stage_active)
        else $error("valid stage not applied");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    chk_low_top_zero: assert property (i_rd && blk && i_addr[2:0] == 3'h0 |=> o_rdata[15:14] == 2'b00)
        else $error("unused bits of first register set");
    chk_hole_zero: assert property (i_rd && blk && i_addr[2:1] != 2'b00 |=> o_rdata == 16'h0000)
        else $error("unmapped stage offset returned data");
    chk_readback: assert property (i_wr && blk && i_addr[2:0] == 3'h1 ##1 i_rd && $stable(i_addr)
        |=> o_rdata == $past(i_wdata, 2)) else $error("second register readback wrong");
    chk_offset_gate: assert property (o_neg_offset_en || o_pos_offset_en |-> o_stage_active)
        else $error("offset enabled while idle");
endmodule // sicc_props

bind sicc_stage_config sicc_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stage(i_stage), .o_pos_sel(o_pos_sel), .o_neg_sel(o_neg_sel),
    .o_bias_sel(o_bias_sel), .o_se_pos(o_se_pos), .o_se_neg(o_se_neg), .o_diff(o_diff), .o_type_bad(o_type_bad),
    .o_neg_offset_en(o_neg_offset_en), .o_pos_offset_en(o_pos_offset_en), .o_stage_active(o_stage_active));

// ==== tb/tb.sv ====
// Testbench for the stage connection configuration bank
`timescale 1ns/10ps
module tb;
    logic        i_clk, i_rst_b, i_wr, i_rd;
    logic [9:0]  i_addr;
    logic [15:0] i_wdata;
    logic [3:0]  i_stage;
    wire  [15:0] o_rdata;
    wire  [12:0] o_pos_sel, o_neg_sel, o_bias_sel;
    wire         o_se_pos, o_se_neg, o_diff, o_type_bad;
    wire         o_neg_offset_en, o_pos_offset_en, o_stage_active;
    int          errors, n_compared;
    logic [15:0] lo_m [12];
    logic [15:0] hi_m [12];

    sicc_stage_config DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stage(i_stage), .o_pos_sel(o_pos_sel), .o_neg_sel(o_neg_sel),
        .o_bias_sel(o_bias_sel), .o_se_pos(o_se_pos), .o_se_neg(o_se_neg), .o_diff(o_diff), .o_type_bad(o_type_bad),
        .o_neg_offset_en(o_neg_offset_en), .o_pos_offset_en(o_pos_offset_en), .o_stage_active(o_stage_active));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write ends on the edge, so a read may follow with no gap
    task wr(input logic [9:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task rd(input logic [9:0] a, input logic [15:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        cmp("rdata", e, o_rdata);
        @(posedge i_clk);
    endtask

    function automatic logic [12:0] sel(input int s, input logic [1:0] c);
        logic [25:0] w;
        w = {hi_m[s][11:0], lo_m[s][13:0]};
        for (int i = 0; i < 13; i++)
            sel[i] = w[2*i +: 2] === c;
    endfunction

    task chk_st(input logic [3:0] s);
        logic       v;
        logic [1:0] t;
        v = s < 4'hc;
        t = v ? hi_m[s][13:12] : 2'h0;
        i_stage <= s;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        cmp("pos_sel", v ? sel(s, 2'h2) : 13'h0000, o_pos_sel);
        cmp("neg_sel", v ? sel(s, 2'h1) : 13'h0000, o_neg_sel);
        cmp("bias_sel", v ? sel(s, 2'h3) : 13'h0000, o_bias_sel);
        cmp("type", {t == 2'h3, t == 2'h2, t == 2'h1, v && t == 2'h0}, {o_diff, o_se_neg, o_se_pos, o_type_bad});
        cmp("offset_en", {v && !hi_m[s][15], v && !hi_m[s][14], v}, {o_pos_offset_en, o_neg_offset_en, o_stage_active});
        @(posedge i_clk);
    endtask

    task t_map;
        logic [9:0] a;
        for (int s = 0; s < 12; s++) begin
            a = 10'h080 + 10'(8 * s);
            lo_m[s] = 16'(16'h1b6c + 16'h2e93 * s) & 16'h3fff;
            hi_m[s] = 16'(16'h5a17 + 16'h4c2d * s) | 16'h3000;
            wr(a, lo_m[s]);
            rd(a, lo_m[s]);
            wr(a + 10'h001, hi_m[s]);
            rd(a + 10'h001, hi_m[s]);
        end
        for (int s = 0; s < 12; s++) begin
            rd(10'h080 + 10'(8 * s), lo_m[s]);
            chk_st(4'(s));
        end
        $display("t_map done");
    endtask

    task t_holes;
        wr(10'h082, 16'hffff);
        rd(10'h082, 16'h0000);
        rd(10'h080, lo_m[0]);
        rd(10'h0df, 16'h0000);
        rd(10'h000, 16'h0000);
        chk_st(4'hc);
        chk_st(4'hf);
        $display("t_holes done");
    endtask

    // Type 00 is a deliberate misuse; single-ended types route one input, differential routes inputs 0 and 1
    task t_types;
        for (int t = 0; t < 4; t++) begin
            lo_m[4] = t == 2 ? 16'h3ffd : t == 3 ? 16'h3ff6 : 16'h3ffe;
            hi_m[4] = {2'(t), 2'(t), 12'hfff};
            wr(10'h0a0, lo_m[4]);
            rd(10'h0a0, lo_m[4]);
            wr(10'h0a1, hi_m[4]);
            rd(10'h0a1, hi_m[4]);
            chk_st(4'h4);
            // Status: sticky flag survives until cleared after the bad type goes away
            rd(10'h0e0, {7'h00, t < 2, 1'b0, 2'(t), 1'b1, 4'h4});
            wr(10'h0e0, 16'h0100);
            rd(10'h0e0, {7'h00, t == 0, 1'b0, 2'(t), 1'b1, 4'h4});
        end
        $display("t_types done");
    endtask

    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 10'h000;
        i_wdata = 16'h0000;
        i_stage = 4'hc;
        errors = 0;
        n_compared = 0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        t_map;
        t_holes;
        t_types;
        tally_and_finish;
    end

    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
endmodule // tb
